// *** hdl/sio_cfg_pkg.sv ***
package sio_cfg_pkg;
   // ****************************************
   // Access keys and indices
   // ****************************************
   localparam logic [7:0] KEY_LOW = 8'h88;
   localparam logic [7:0] KEY_HIGH = 8'h89;
   localparam logic [7:0] IDX_FLOPPY = 8'h08;
   localparam logic [7:0] IDX_MODE_LOCK = 8'h09;
   localparam logic [7:0] IDX_PORTABLE = 8'h0a;
   localparam logic [7:0] IDX_RSVD_B = 8'h0b;
   localparam logic [7:0] IDX_UART_IR = 8'h0c;
   localparam logic [7:0] IDX_IR_ROUTE = 8'h0d;
   localparam logic [7:0] IDX_LOCK_LAST = 8'h0b;
   // ****************************************
   // Port select codes
   // ****************************************
   localparam logic [1:0] PORT_ENABLE = 2'h0;
   localparam logic [1:0] PORT_INDEX = 2'h1;
   localparam logic [1:0] PORT_DATA = 2'h2;
   localparam logic [1:0] PORT_DRIVE_TYPE = 2'h3;
   // ****************************************
   // Field positions and reset values
   // ****************************************
   localparam int FLP_WRITE_BLOCK = 5;
   localparam int FLP_SOFT_WP = 4;
   localparam int ML_MODE_HI = 7;
   localparam int ML_LOCK = 6;
   localparam int ML_THREE_MODE = 5;
   localparam int PC_FLOPPY_POL = 7;
   localparam int PC_EXT_POL = 6;
   localparam int PC_DIR_POL = 5;
   localparam int PC_DOCK_POL = 4;
   localparam int UC_CLK_A = 7;
   localparam int UC_CLK_B = 6;
   localparam int UC_KEY_SEL = 5;
   localparam int UC_IR_SEL = 3;
   localparam int UC_GPIO_SEL = 2;
   localparam int UC_RX_INV = 1;
   localparam int UC_TX_INV = 0;
   localparam int IR_DUPLEX = 3;
   localparam int DT_CURRENT_LO = 4;
   localparam logic [7:0] FLOPPY_RESET = 8'h00;
   localparam logic [7:0] MODE_LOCK_RESET = 8'h00;
   localparam logic [7:0] PORTABLE_RESET = 8'h00;
   localparam logic [7:0] IR_ROUTE_RESET = 8'h00;
   localparam logic [7:0] DRIVE_TYPE_RESET = 8'h00;
   localparam logic [7:0] UART_IR_RW_MASK = 8'hc3;
   localparam logic [7:0] MODE_LOCK_RW_MASK = 8'he0;
   localparam logic [7:0] IR_ROUTE_RW_MASK = 8'hf8;
   localparam logic [7:0] DRIVE_TYPE_RW_MASK = 8'h30;
   // Uart clock: 24 MHz divided by 13
   localparam int UART_DIV = 13;
   localparam logic [3:0] UART_DIV_LAST = 4'hc;

   // Parallel port modes seen by the extension enable
   typedef struct packed {
      logic adapter;
      logic epp;
      logic ecp;
      logic combined;
   } sio_par_mode_s;

   // Host access strobes with data
   typedef struct packed {
      logic [1:0] port;
      logic wr;
      logic rd;
      logic [7:0] data;
   } sio_host_s;
endpackage : sio_cfg_pkg

// *** hdl/sio_cfg_regs.sv ***
`timescale 1ns/1ps
module sio_cfg_regs
   import sio_cfg_pkg::*;
#(
   parameter logic [3:0] CHIP_ID = 4'h5 // Arbitrary value
) (
   input wire logic clock_in,
   input wire logic reset_in,
   input wire sio_host_s host_in,
   output logic [7:0] read_data_out,
   input wire logic strap_key_sel_in,
   input wire logic strap_ir_sel_in,
   input wire logic strap_gpio_sel_in,
   input wire logic fdc_write_gate_in,
   input wire logic fdc_write_data_in,
   output logic floppy_write_gate_out,
   output logic floppy_write_stream_out,
   input wire logic drive_write_protect_in,
   output logic write_protect_out,
   input wire logic rate_high_in,
   output logic reduced_write_current_out,
   input wire logic portable_floppy_active_in,
   output logic portable_floppy_enable_out,
   input wire sio_par_mode_s par_mode_in,
   output logic extension_enable_out,
   input wire logic par_bus_input_in,
   input wire logic dock_detect_in,
   output logic dock_detect_out,
   output logic [2:0] parallel_mode_sel_hi_out,
   output logic uart_a_clock_out,
   output logic uart_b_clock_out,
   output logic uart_b_infrared_select_out,
   output logic disk_or_gpio_select_out,
   output logic half_duplex_out,
   input wire logic [1:0] parallel_mode_lo_in,
   input wire logic uart_b_tx_in,
   output logic serial_b_output_out,
   output logic data_bus_direction_out,
   output logic chip_select_one_pin_out,
   input wire logic serial_b_input_in,
   input wire logic chip_select_zero_pin_in,
   input wire logic reside_pin_in,
   output logic uart_b_rx_out
);
   // ****************************************
   // Access path
   // ****************************************
   logic [7:0] function_enable_reg;
   logic [7:0] function_index_reg;
   logic [7:0] floppy_protect_config_reg;
   logic [7:0] mode_lock_id_reg;
   logic [7:0] portable_pin_control_reg;
   logic [7:0] uart_clock_ir_select_reg;
   logic [7:0] ir_pin_route_reg;
   logic [7:0] drive_type_reg;
   logic strap_pending_reg;
   logic [3:0] div_count_reg;
   logic div_clock_reg;
   logic [7:0] key_value;
   logic unlocked;
   logic locked_index;
   logic data_wr;
   logic data_rd;
   logic [7:0] cfg_read;

   assign key_value = uart_clock_ir_select_reg[UC_KEY_SEL] ? KEY_HIGH : KEY_LOW;
   assign unlocked = (function_enable_reg == key_value);
   assign locked_index = mode_lock_id_reg[ML_LOCK] && (function_index_reg <= IDX_LOCK_LAST);
   assign data_wr = host_in.wr && host_in.port == PORT_DATA && unlocked && !locked_index;
   assign data_rd = host_in.rd && host_in.port == PORT_DATA && unlocked;

   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         function_enable_reg <= 8'h00;
         function_index_reg <= 8'h00;
      end else begin
         if (host_in.wr && host_in.port == PORT_ENABLE) begin
            function_enable_reg <= host_in.data;
         end
         if (host_in.wr && host_in.port == PORT_INDEX && unlocked) begin
            function_index_reg <= host_in.data;
         end
      end
   end

   // ****************************************
   // Configuration registers
   // ****************************************
   // Mode/lock is index 09, inside the locked range, so it stays writable
   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         mode_lock_id_reg <= MODE_LOCK_RESET;
      end else if (host_in.wr && host_in.port == PORT_DATA && unlocked &&
                   function_index_reg == IDX_MODE_LOCK) begin
         mode_lock_id_reg <= host_in.data & MODE_LOCK_RW_MASK;
      end
   end

   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         floppy_protect_config_reg <= FLOPPY_RESET;
         portable_pin_control_reg <= PORTABLE_RESET;
         ir_pin_route_reg <= IR_ROUTE_RESET;
      end else if (data_wr) begin
         if (function_index_reg == IDX_FLOPPY) begin
            floppy_protect_config_reg <= host_in.data;
         end
         if (function_index_reg == IDX_PORTABLE) begin
            portable_pin_control_reg <= host_in.data;
         end
         if (function_index_reg == IDX_IR_ROUTE) begin
            ir_pin_route_reg <= host_in.data & IR_ROUTE_RW_MASK;
         end
      end
   end

   // Straps are caught by a clocked load just after reset release
   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         strap_pending_reg <= 1'b1;
         uart_clock_ir_select_reg <= 8'h00;
      end else if (strap_pending_reg) begin
         strap_pending_reg <= 1'b0;
         uart_clock_ir_select_reg[UC_KEY_SEL] <= strap_key_sel_in;
         uart_clock_ir_select_reg[UC_IR_SEL] <= strap_ir_sel_in;
         uart_clock_ir_select_reg[UC_GPIO_SEL] <= strap_gpio_sel_in;
      end else if (data_wr && function_index_reg == IDX_UART_IR) begin
         // Strap bits keep their loaded value, or one write could move the key away
         uart_clock_ir_select_reg <= (host_in.data & UART_IR_RW_MASK) |
            (uart_clock_ir_select_reg & ~UART_IR_RW_MASK);
      end
   end

   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         drive_type_reg <= DRIVE_TYPE_RESET;
      end else if (host_in.wr && host_in.port == PORT_DRIVE_TYPE &&
                   mode_lock_id_reg[ML_THREE_MODE]) begin
         drive_type_reg <= host_in.data & DRIVE_TYPE_RW_MASK;
      end
   end

   always_comb begin
      unique case (function_index_reg)
         IDX_FLOPPY: cfg_read = floppy_protect_config_reg;
         IDX_MODE_LOCK: cfg_read = {mode_lock_id_reg[7:4], CHIP_ID};
         IDX_PORTABLE: cfg_read = portable_pin_control_reg;
         IDX_UART_IR: cfg_read = uart_clock_ir_select_reg;
         IDX_IR_ROUTE: cfg_read = ir_pin_route_reg;
         default: cfg_read = 8'h00;
      endcase
   end

   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         read_data_out <= 8'h00;
      end else if (data_rd) begin
         read_data_out <= locked_index ? 8'h00 : cfg_read;
      end else if (host_in.rd && host_in.port == PORT_DRIVE_TYPE) begin
         read_data_out <= mode_lock_id_reg[ML_THREE_MODE] ? drive_type_reg : 8'h00;
      end else if (host_in.rd && host_in.port == PORT_INDEX) begin
         read_data_out <= function_index_reg;
      end
   end

   // ****************************************
   // Uart clock divider
   // ****************************************
   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         div_count_reg <= 4'h0;
         div_clock_reg <= 1'b0;
      end else begin
         div_count_reg <= (div_count_reg == UART_DIV_LAST) ? 4'h0 : div_count_reg + 4'h1;
         div_clock_reg <= (div_count_reg == UART_DIV_LAST);
      end
   end

   // Enables at 24 MHz rate are the system clock itself, here a steady one
   assign uart_a_clock_out = uart_clock_ir_select_reg[UC_CLK_A] ? 1'b1 : div_clock_reg;
   assign uart_b_clock_out = uart_clock_ir_select_reg[UC_CLK_B] ? 1'b1 : div_clock_reg;

   // ****************************************
   // Pin control
   // ****************************************
   logic [1:0] current_mode;
   logic ext_allowed;
   logic ir_mode;
   logic tx_bit;
   logic rx_raw;

   assign current_mode = drive_type_reg[DT_CURRENT_LO +: 2];
   assign floppy_write_gate_out =
      floppy_protect_config_reg[FLP_WRITE_BLOCK] ? 1'b1 : fdc_write_gate_in;
   assign floppy_write_stream_out =
      floppy_protect_config_reg[FLP_WRITE_BLOCK] ? 1'b1 : fdc_write_data_in;
   assign write_protect_out =
      floppy_protect_config_reg[FLP_SOFT_WP] ? 1'b1 : drive_write_protect_in;
   // Undefined code 11 holds normal signalling
   assign reduced_write_current_out = (!mode_lock_id_reg[ML_THREE_MODE] ||
      current_mode == 2'b00 || current_mode == 2'b11) ?
      rate_high_in : current_mode[1];
   assign portable_floppy_enable_out =
      portable_floppy_active_in ~^ portable_pin_control_reg[PC_FLOPPY_POL];
   assign ext_allowed = |(portable_pin_control_reg[3:0] & par_mode_in);
   assign extension_enable_out =
      ext_allowed ~^ portable_pin_control_reg[PC_EXT_POL];
   assign dock_detect_out = dock_detect_in ~^ portable_pin_control_reg[PC_DOCK_POL];
   assign parallel_mode_sel_hi_out =
      {mode_lock_id_reg[ML_MODE_HI], parallel_mode_lo_in};
   assign uart_b_infrared_select_out = uart_clock_ir_select_reg[UC_IR_SEL];
   assign disk_or_gpio_select_out = uart_clock_ir_select_reg[UC_GPIO_SEL];
   assign half_duplex_out = ir_pin_route_reg[IR_DUPLEX];

   // ****************************************
   // Infrared routing
   // ****************************************
   assign ir_mode = !uart_clock_ir_select_reg[UC_IR_SEL];
   assign tx_bit = uart_b_tx_in ^ uart_clock_ir_select_reg[UC_TX_INV];
   always_comb begin
      serial_b_output_out = tx_bit;
      data_bus_direction_out = par_bus_input_in ^ portable_pin_control_reg[PC_DIR_POL];
      chip_select_one_pin_out = 1'b1;
      if (ir_mode) begin
         unique case (ir_pin_route_reg[7:6])
            2'b01: serial_b_output_out = tx_bit;
            2'b10: chip_select_one_pin_out = tx_bit;
            default: data_bus_direction_out = tx_bit;
         endcase
      end
   end

   always_comb begin
      rx_raw = serial_b_input_in;
      if (ir_mode) begin
         unique case (ir_pin_route_reg[5:4])
            2'b00: rx_raw = dock_detect_in;
            2'b01: rx_raw = serial_b_input_in;
            2'b10: rx_raw = chip_select_zero_pin_in;
            2'b11: rx_raw = reside_pin_in;
         endcase
      end
   end
   assign uart_b_rx_out = rx_raw ^ uart_clock_ir_select_reg[UC_RX_INV];

   // ****************************************
   // Checks
   // ****************************************
   a_write_block: assert property (@(posedge clock_in) disable iff (reset_in)
      floppy_protect_config_reg[FLP_WRITE_BLOCK] |-> floppy_write_gate_out && floppy_write_stream_out)
      else $error("write block not forcing high");
   a_soft_protect: assert property (@(posedge clock_in) disable iff (reset_in)
      floppy_protect_config_reg[FLP_SOFT_WP] |-> write_protect_out)
      else $error("soft protect not reported");
   a_key_gate: assert property (@(posedge clock_in) disable iff (reset_in)
      (host_in.wr && host_in.port == PORT_DATA && !unlocked) |=> $stable(portable_pin_control_reg))
      else $error("write accepted without key");
   a_lock_read: assert property (@(posedge clock_in) disable iff (reset_in)
      (data_rd && locked_index) |=> read_data_out == 8'h00)
      else $error("locked read returned data");
   a_lock_write: assert property (@(posedge clock_in) disable iff (reset_in)
      (host_in.wr && host_in.port == PORT_DATA && locked_index)
      |=> $stable(floppy_protect_config_reg) && $stable(portable_pin_control_reg))
      else $error("locked register changed");
   a_chip_id: assert property (@(posedge clock_in) disable iff (reset_in)
      (data_rd && !mode_lock_id_reg[ML_LOCK] && function_index_reg == IDX_MODE_LOCK)
      |=> read_data_out[3:0] == CHIP_ID)
      else $error("chip id wrong");
   a_current_forced: assert property (@(posedge clock_in) disable iff (reset_in)
      (mode_lock_id_reg[ML_THREE_MODE] && current_mode == 2'b10) |-> reduced_write_current_out)
      else $error("rate output not forced high");
   a_current_low: assert property (@(posedge clock_in) disable iff (reset_in)
      (mode_lock_id_reg[ML_THREE_MODE] && current_mode == 2'b01) |-> !reduced_write_current_out)
      else $error("rate output not forced low");
   a_drive_closed: assert property (@(posedge clock_in) disable iff (reset_in)
      (host_in.wr && host_in.port == PORT_DRIVE_TYPE && !mode_lock_id_reg[ML_THREE_MODE])
      |=> $stable(drive_type_reg))
      else $error("drive type written while closed");
   a_strap_load: assert property (@(posedge clock_in) disable iff (reset_in)
      strap_pending_reg |=> uart_clock_ir_select_reg[UC_KEY_SEL] == $past(strap_key_sel_in))
      else $error("strap not captured");
   a_ext_off: assert property (@(posedge clock_in) disable iff (reset_in)
      (portable_pin_control_reg[3:0] == 4'h0)
      |-> extension_enable_out == !portable_pin_control_reg[PC_EXT_POL])
      else $error("extension enable active while disallowed");
   c_unlock_write: cover property (@(posedge clock_in) disable iff (reset_in) data_wr);
   c_locked_read: cover property (@(posedge clock_in) disable iff (reset_in)
      data_rd && locked_index);
   c_ir_route: cover property (@(posedge clock_in) disable iff (reset_in)
      ir_mode && ir_pin_route_reg[7:6] == 2'b10);
   a_index_key: assert property (@(posedge clock_in) disable iff (reset_in)
      (host_in.wr && host_in.port == PORT_INDEX && !unlocked) |=> $stable(function_index_reg))
      else $error("index written without key");
   a_lock_clear: assert property (@(posedge clock_in) disable iff (reset_in)
      (host_in.wr && host_in.port == PORT_DATA && unlocked &&
      function_index_reg == IDX_MODE_LOCK)
      |=> mode_lock_id_reg == ($past(host_in.data) & MODE_LOCK_RW_MASK))
      else $error("mode register write lost");
   a_strap_hold: assert property (@(posedge clock_in) disable iff (reset_in)
      (!strap_pending_reg && data_wr && function_index_reg == IDX_UART_IR)
      |=> $stable(uart_clock_ir_select_reg[UC_KEY_SEL]))
      else $error("key select followed host data");
   a_drive_open: assert property (@(posedge clock_in) disable iff (reset_in)
      (host_in.rd && host_in.port == PORT_DRIVE_TYPE && mode_lock_id_reg[ML_THREE_MODE])
      |=> read_data_out == $past(drive_type_reg))
      else $error("drive type read wrong");
   a_div_period: assert property (@(posedge clock_in) disable iff (reset_in)
      div_clock_reg |-> ##13 div_clock_reg)
      else $error("divided enable period wrong");
   a_cs1_route: assert property (@(posedge clock_in) disable iff (reset_in)
      (ir_mode && ir_pin_route_reg[7:6] == 2'b10)
      |-> chip_select_one_pin_out == (uart_b_tx_in ^ uart_clock_ir_select_reg[UC_TX_INV]))
      else $error("infrared transmit not on chip select one");
   a_cs1_idle: assert property (@(posedge clock_in) disable iff (reset_in)
      (!ir_mode || ir_pin_route_reg[7:6] != 2'b10) |-> chip_select_one_pin_out)
      else $error("chip select one left its idle level");
   a_reside_route: assert property (@(posedge clock_in) disable iff (reset_in)
      (ir_mode && ir_pin_route_reg[5:4] == 2'b11)
      |-> uart_b_rx_out == (reside_pin_in ^ uart_clock_ir_select_reg[UC_RX_INV]))
      else $error("reside pin not routed to receive");
   c_lock_mode_write: cover property (@(posedge clock_in) disable iff (reset_in)
      mode_lock_id_reg[ML_LOCK] && host_in.wr && host_in.port == PORT_DATA &&
      function_index_reg == IDX_MODE_LOCK);
   c_current_undefined: cover property (@(posedge clock_in) disable iff (reset_in)
      mode_lock_id_reg[ML_THREE_MODE] && current_mode == 2'b11);
endmodule : sio_cfg_regs

// *** tb/sio_cfg_regs_test.sv ***
`timescale 1ns/1ps
module sio_cfg_regs_test;
   import sio_cfg_pkg::*;
   localparam logic [3:0] TB_CHIP_ID = 4'h6; // Arbitrary value
   logic clock_in;
   logic reset_in;
   sio_host_s host_in;
   logic [2:0] straps; // {key, infrared, gpio}
   // {par lo, par mode, reside, cs0, sin, tx, dock, bus in, pf act, rate, wp, wdat, wg}
   logic [16:0] pins;
   logic [7:0] read_data_out;
   logic wg_out, ws_out, wp_out, current_out, pf_out, ext_out, dock_out, dir_out;
   logic [2:0] mode_out;
   logic clk_a, clk_b, ir_sel, gpio_sel, duplex, sout, cs1_out, rx_out;
   int errors;
   int total_checks;

   sio_cfg_regs #(.CHIP_ID(TB_CHIP_ID)) sio_cfg_regs_i (
      .clock_in(clock_in), .reset_in(reset_in), .host_in(host_in),
      .read_data_out(read_data_out), .strap_key_sel_in(straps[2]),
      .strap_ir_sel_in(straps[1]), .strap_gpio_sel_in(straps[0]),
      .fdc_write_gate_in(pins[0]), .fdc_write_data_in(pins[1]),
      .floppy_write_gate_out(wg_out), .floppy_write_stream_out(ws_out),
      .drive_write_protect_in(pins[2]), .write_protect_out(wp_out),
      .rate_high_in(pins[3]), .reduced_write_current_out(current_out),
      .portable_floppy_active_in(pins[4]), .portable_floppy_enable_out(pf_out),
      .par_mode_in(sio_par_mode_s'(pins[14:11])), .extension_enable_out(ext_out),
      .par_bus_input_in(pins[5]), .dock_detect_in(pins[6]), .dock_detect_out(dock_out),
      .parallel_mode_sel_hi_out(mode_out), .uart_a_clock_out(clk_a),
      .uart_b_clock_out(clk_b), .uart_b_infrared_select_out(ir_sel),
      .disk_or_gpio_select_out(gpio_sel), .half_duplex_out(duplex),
      .parallel_mode_lo_in(pins[16:15]), .uart_b_tx_in(pins[7]),
      .serial_b_output_out(sout), .data_bus_direction_out(dir_out),
      .chip_select_one_pin_out(cs1_out), .serial_b_input_in(pins[8]),
      .chip_select_zero_pin_in(pins[9]), .reside_pin_in(pins[10]), .uart_b_rx_out(rx_out));

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic wr(input logic [1:0] port, input logic [7:0] d);
      @(posedge clock_in);
      host_in <= '{port: port, wr: 1'b1, rd: 1'b0, data: d};
      @(posedge clock_in);
      host_in <= '0;
   endtask : wr

   // Read data is registered, so it is looked at after the taking edge
   task automatic rd(input logic [1:0] port, input logic [7:0] exp);
      @(posedge clock_in);
      host_in <= '{port: port, wr: 1'b0, rd: 1'b1, data: 8'h00};
      @(posedge clock_in);
      host_in <= '0;
      @(negedge clock_in);
      check(read_data_out, exp);
   endtask : rd

   task automatic wreg(input logic [7:0] idx, input logic [7:0] d);
      wr(PORT_ENABLE, KEY_HIGH);
      wr(PORT_INDEX, idx);
      wr(PORT_DATA, d);
   endtask : wreg

   task automatic rreg(input logic [7:0] idx, input logic [7:0] exp);
      wr(PORT_ENABLE, KEY_HIGH);
      wr(PORT_INDEX, idx);
      rd(PORT_DATA, exp);
   endtask : rreg

   task automatic setp(input logic [16:0] v);
      @(posedge clock_in);
      pins <= v;
      @(negedge clock_in);
   endtask : setp

   task automatic rst(input logic [2:0] s);
      @(posedge clock_in);
      straps <= s;
      reset_in <= 1'b1;
      repeat (6) @(posedge clock_in);
      reset_in <= 1'b0;
      repeat (2) @(posedge clock_in);
   endtask : rst

   // Two windows of 13 cycles hold two enable pulses when divided
   task automatic cnt(input bit b, input int exp);
      int n;
      n = 0;
      repeat (2 * UART_DIV) begin
         @(negedge clock_in);
         n += b ? clk_b : clk_a;
      end
      check(n[7:0], exp[7:0]);
   endtask : cnt

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_defaults;
      rreg(IDX_UART_IR, 8'h2c);
      rreg(IDX_IR_ROUTE, 8'h00);
      rreg(IDX_MODE_LOCK, {4'h0, TB_CHIP_ID});
      rreg(IDX_RSVD_B, 8'h00);
   endtask : t_defaults

   task automatic t_floppy;
      wreg(IDX_FLOPPY, 8'h3b);
      setp(17'h0);
      check(wg_out, 1'b1);
      check(ws_out, 1'b1);
      check(wp_out, 1'b1);
      rreg(IDX_FLOPPY, 8'h3b);
      wreg(IDX_FLOPPY, 8'h00);
      setp(17'h4);
      check(wp_out, 1'b1);
      check(wg_out, 1'b0);
      setp(17'h3);
      check({wp_out, wg_out, ws_out}, 3'b011);
   endtask : t_floppy

   task automatic t_lock;
      wreg(IDX_MODE_LOCK, 8'haf);
      rreg(IDX_MODE_LOCK, {4'ha, TB_CHIP_ID});
      setp(17'h10000);
      check(mode_out, 3'b110);
      wreg(IDX_PORTABLE, 8'h5a);
      // Wrong key: the data and index writes that follow must be dropped
      wr(PORT_ENABLE, KEY_LOW);
      wr(PORT_DATA, 8'hff);
      wr(PORT_INDEX, IDX_FLOPPY);
      rd(PORT_INDEX, IDX_PORTABLE);
      rreg(IDX_PORTABLE, 8'h5a);
      wreg(IDX_MODE_LOCK, 8'he0);
      wreg(IDX_PORTABLE, 8'hff);
      rreg(IDX_PORTABLE, 8'h00);
      wreg(IDX_IR_ROUTE, 8'h40);
      rreg(IDX_IR_ROUTE, 8'h40);
      wreg(IDX_MODE_LOCK, 8'h00);
      rreg(IDX_PORTABLE, 8'h5a);
      wreg(IDX_IR_ROUTE, 8'h00);
   endtask : t_lock

   task automatic t_drive;
      logic exp;
      wr(PORT_DRIVE_TYPE, 8'h20);
      rd(PORT_DRIVE_TYPE, 8'h00);
      wreg(IDX_MODE_LOCK, 8'h20);
      for (int v = 0; v < 4; v++) begin
         wr(PORT_DRIVE_TYPE, 8'(v << 4));
         for (int r = 0; r < 2; r++) begin
            setp(17'(r << 3));
            exp = (v == 0 || v == 3) ? r[0] : (v == 2);
            check(current_out, exp);
         end
      end
      rd(PORT_DRIVE_TYPE, 8'h30);
   endtask : t_drive

   task automatic t_portable;
      logic [7:0] cfg [4] = '{8'h00, 8'hf8, 8'h54, 8'ha3};
      logic [7:0] c;
      logic [3:0] m;
      logic [1:0] j;
      for (int i = 0; i < 4; i++) begin
         c = cfg[i];
         wreg(IDX_PORTABLE, c);
         for (int k = 0; k < 4; k++) begin
            j = k[1:0];
            m = 4'b1000 >> k;
            setp({2'b00, m, 4'b0000, j[0] ^ j[1], j[1], j[0], 4'h0});
            check(pf_out, j[0] ? c[7] : !c[7]);
            check(ext_out, (|(m & c[3:0])) == c[6]);
            check(dir_out, j[1] ^ c[5]);
            check(dock_out, (j[0] ^ j[1]) == c[4]);
         end
      end
   endtask : t_portable

   task automatic t_uart;
      cnt(1'b0, 2);
      cnt(1'b1, 2);
      wreg(IDX_UART_IR, 8'hc3);
      rreg(IDX_UART_IR, 8'hef);
      cnt(1'b0, 26);
      cnt(1'b1, 26);
      setp(17'h180);
      check({sout, rx_out}, 2'b00);
      check({ir_sel, gpio_sel}, 2'b11);
      wreg(IDX_UART_IR, 8'h00);
   endtask : t_uart

   // Infrared routing needs the strap low, so this runs under a second reset
   task automatic t_ir;
      logic [1:0] k;
      rst(3'h5);
      rreg(IDX_UART_IR, 8'h24);
      for (int p = 0; p < 2; p++) begin
         for (int s = 0; s < 4; s++) begin
            k = s[1:0];
            wreg(IDX_IR_ROUTE, {k, k, p[0], 3'h0});
            setp({6'h0, p[0], ~p[0], p[0], p[0], ~p[0], 6'h0});
            check(duplex, p[0]);
            check(rx_out, k[0] ? p[0] : !p[0]);
            check(k == 2'b01 ? sout : k == 2'b10 ? cs1_out : dir_out, p[0]);
         end
      end
      wreg(IDX_UART_IR, 8'h03);
      wreg(IDX_IR_ROUTE, 8'h00);
      setp(17'h780);
      check({rx_out, dir_out}, 2'b10);
      rst(3'h7);
   endtask : t_ir

   // ****************************************
   // Run control
   // ****************************************
   task automatic final_report;
      $display("errors=%0d total_checks=%0d", errors, total_checks);
      if (errors == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : final_report

   initial begin
      clock_in = 1'b0;
      forever #5 clock_in = ~clock_in;
   end

   // Cuts a hang short well beyond the few hundred cycles the run needs
   initial begin
      #1000000;
      errors++;
      final_report();
   end

   initial begin
      errors = 0;
      total_checks = 0;
      reset_in = 1'b1;
      host_in = '0;
      straps = 3'h7;
      pins = '0;
      rst(3'h7);
      t_defaults();
      t_floppy();
      t_lock();
      t_drive();
      t_portable();
      t_uart();
      t_ir();
      final_report();
   end
endmodule : sio_cfg_regs_test
